// ---- hw/tds_pkg.sv ----
package tds_pkg;
  // ------------------------------------------------------------
  // Clock, tick and widths
  // ------------------------------------------------------------
  localparam int CLK_MHZ  = 125;                      // Reference clock rate
  localparam int TICK_MS  = 25;                       // Prescaled tick period
  localparam int TICK_CYC = TICK_MS * CLK_MHZ * 1000; // Cycles per tick
  localparam int T_W      = 12;                       // Window counter width
  localparam int B_W      = 6;                        // Beep counter width
  localparam int CODE_W   = 16;                       // System code width
  localparam int KEY_W    = 8;                        // Key identity width
  localparam int KEYS     = 4;                        // Enrollable key slots
  localparam logic [CODE_W-1:0] LFSR_SEED = 16'hace1; // Code generator seed
  localparam logic [CODE_W-1:0] CODE_RST  = 16'h0000; // Code after reset

  // ------------------------------------------------------------
  // Times in milliseconds
  // ------------------------------------------------------------
  localparam int SLEEP_MS  = 2500;  // Armed blink period
  localparam int FLASH_MS  = 100;   // Armed flash on-time
  localparam int F2_MS     = 500;   // Two flashes per second
  localparam int F1_MS     = 1000;  // One flash per second
  localparam int FH_MS     = 2000;  // One flash per two seconds
  localparam int F10_MS    = 100;   // Ten flashes per second
  localparam int BURST_MS  = 1500;  // One second burst plus pause
  localparam int SEC_MS    = 1000;  // One second
  localparam int SHORT_MS  = 200;   // Short beep
  localparam int LONG_MS   = 1000;  // Long beep
  localparam int SETTLE_MS = 4000;  // Delay after ignition off
  localparam int WIN_MS    = 10000; // Step window
  localparam int PMIN_MS   = 1000;  // Shortest ignition pulse
  localparam int PMAX_MS   = 2000;  // Longest ignition pulse
  localparam int LEDOFF_MS = 2000;  // Indicator hold before confirm
  localparam int ABORT_MS  = 2000;  // Abort pattern length
  localparam int OFF15_MS  = 15000; // Resync ignition off time
  localparam int NEWCTL_MS = 20000; // New controller light time
  localparam int ARM_MS    = 60000; // Door close to armed sleep

  // ------------------------------------------------------------
  // Times in ticks
  // ------------------------------------------------------------
  localparam logic [T_W-1:0] SLEEP_T  = T_W'(SLEEP_MS / TICK_MS);
  localparam logic [T_W-1:0] FLASH_T  = T_W'(FLASH_MS / TICK_MS);
  localparam logic [T_W-1:0] F2_T     = T_W'(F2_MS / TICK_MS);
  localparam logic [T_W-1:0] F1_T     = T_W'(F1_MS / TICK_MS);
  localparam logic [T_W-1:0] FH_T     = T_W'(FH_MS / TICK_MS);
  localparam logic [T_W-1:0] F10_T    = T_W'(F10_MS / TICK_MS);
  localparam logic [T_W-1:0] BURST_T  = T_W'(BURST_MS / TICK_MS);
  localparam logic [T_W-1:0] SEC_T    = T_W'(SEC_MS / TICK_MS);
  localparam logic [T_W-1:0] SETTLE_T = T_W'(SETTLE_MS / TICK_MS);
  localparam logic [T_W-1:0] WIN_T    = T_W'(WIN_MS / TICK_MS);
  localparam logic [T_W-1:0] PMIN_T   = T_W'(PMIN_MS / TICK_MS);
  localparam logic [T_W-1:0] PMAX_T   = T_W'(PMAX_MS / TICK_MS);
  localparam logic [T_W-1:0] LEDOFF_T = T_W'(LEDOFF_MS / TICK_MS);
  localparam logic [T_W-1:0] ABORT_T  = T_W'(ABORT_MS / TICK_MS);
  localparam logic [T_W-1:0] OFF15_T  = T_W'(OFF15_MS / TICK_MS);
  localparam logic [T_W-1:0] NEWCTL_T = T_W'(NEWCTL_MS / TICK_MS);
  localparam logic [T_W-1:0] ARM_T    = T_W'(ARM_MS / TICK_MS);
  localparam logic [B_W-1:0] SHORT_B  = B_W'(SHORT_MS / TICK_MS);
  localparam logic [B_W-1:0] LONG_B   = B_W'(LONG_MS / TICK_MS);
  localparam logic [B_W-1:0] DBL_B    = B_W'(3 * SHORT_MS / TICK_MS);

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE, ST_SLEEP, ST_READ, ST_RUN, ST_UNSYNC, ST_MK1, ST_WIN1,
    ST_CONF, ST_DONE, ST_SVC_ON, ST_MK2, ST_ENROLL, ST_EXIT, ST_ABORT
  } tds_st_t;

  typedef enum logic [2:0] {
    LED_OFF, LED_ON, LED_SLEEP, LED_2HZ, LED_1HZ, LED_HALF, LED_10HZ, LED_BURST
  } tds_led_t;

  typedef struct packed {
    logic ign;       // Ignition on
    logic door;      // Driver door open
    logic tool;      // Scan tool on diagnostic_connector
    logic ack;       // engine_controller finished exchange
    logic ctl_new;   // engine_controller reports new state
    logic ctl_match; // engine_controller code matches
  } tds_pins_t;

  typedef struct packed {
    logic             present; // A key is at the reader
    logic             master;  // That key is the master key
    logic [KEY_W-1:0] id;      // Identity of the key
  } tds_key_t;

  typedef struct packed {
    logic led;      // Indicator
    logic beep;     // Beeper
    logic fuel;     // Fuel-enable grant
    logic relay;    // Relay closed, tool reaches controller
    logic link_req; // Own exchange on the diagnostic line
    logic code_wr;  // Store code in nvm, controller and master key
    logic learnt;   // Module bound to controller
  } tds_out_t;

  // Indicator level for a pattern at window time t
  function automatic logic led_pat(tds_led_t m, logic [T_W-1:0] t);
    logic [T_W-1:0] b;
    b = t % BURST_T;
    unique case (m)
      LED_OFF:   led_pat = 1'b0;
      LED_ON:    led_pat = 1'b1;
      LED_SLEEP: led_pat = (t % SLEEP_T) < FLASH_T;
      LED_2HZ:   led_pat = (t % F2_T) < (F2_T >> 1);
      LED_1HZ:   led_pat = (t % F1_T) < FLASH_T;
      LED_HALF:  led_pat = (t % FH_T) < FLASH_T;
      LED_10HZ:  led_pat = (t % F10_T) < (F10_T >> 1);
      LED_BURST: led_pat = (b < SEC_T) && ((b % F10_T) < (F10_T >> 1));
    endcase
  endfunction : led_pat
endpackage : tds_pkg

// ---- hw/tds_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module tds_top #(
  parameter int TICK_CYC = tds_pkg::TICK_CYC      // Cycles per tick
) (
  input  wire logic                       ref_clk,  // Clock
  input  wire logic                       reset,    // Async reset
  input  wire tds_pkg::tds_pins_t         pins,     // Pin inputs
  input  wire tds_pkg::tds_key_t          key,      // Key reader
  output var  tds_pkg::tds_out_t          drv,      // Outputs
  output var  logic [tds_pkg::CODE_W-1:0] sys_code  // Current code
);
  import tds_pkg::*;

  localparam int DIV_W = $clog2(TICK_CYC);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  tds_pins_t        s1_r, s2_r;             // Pin synchroniser
  logic [DIV_W-1:0] div_r, div_nxt;         // Tick divider
  logic             tick_r, tick_nxt;       // Tick pulse
  tds_st_t          st_r, st_nxt;           // Mode
  logic [T_W-1:0]   t_r, t_nxt;             // Window time
  logic [T_W-1:0]   off_r, off_nxt;         // Ignition off time
  logic [T_W-1:0]   pw_r, pw_nxt;           // Ignition on time
  logic             ign_q_r, door_q_r;      // Previous levels
  logic             kp_q_r;                 // Previous key presence
  logic             svc_r, svc_nxt;         // Service mode
  logic             learnt_r, learnt_nxt;   // Bound to controller
  logic             resync_r, resync_nxt;   // Resync pending
  logic             arm_r, arm_nxt;         // Arming countdown on
  logic             door_r, door_nxt;       // Door opened, ign off
  logic             link_r, link_nxt;       // Own exchange pending
  logic [B_W-1:0]   bp_r, bp_nxt;           // Beep countdown
  logic             dbl_r, dbl_nxt;         // Double beep
  logic [CODE_W-1:0] lfsr_r;                // Code generator
  logic [CODE_W-1:0] code_r, code_nxt;      // Stored code
  logic [KEYS-1:0]  kok_r, kok_nxt;         // Slot valid
  logic [KEY_W-1:0] kid_r [KEYS];           // Slot identity
  logic [KEY_W-1:0] kid_nxt [KEYS];
  tds_out_t         out_r, out_nxt;         // Registered outputs

  // ------------------------------------------------------------
  // Decoded events
  // ------------------------------------------------------------
  logic    ign_rise, ign_fall, door_close, ord_ev, mk;
  logic    hit, free;
  logic [$clog2(KEYS)-1:0] slot;
  logic    do_code, do_link, rst_t, go_res, cw, beep_on;
  tds_st_t on_st;
  tds_led_t led_m;
  logic [B_W-1:0] bp_load;

  assign ign_rise   = s2_r.ign && !ign_q_r;
  assign ign_fall   = !s2_r.ign && ign_q_r;
  assign door_close = !s2_r.door && door_q_r;
  assign mk         = key.present && key.master;
  assign ord_ev     = key.present && !key.master && !kp_q_r;

  // Key table lookup and first free slot
  always_comb
  begin
    hit  = 1'b0;
    free = 1'b0;
    slot = '0;
    for (int i = KEYS - 1; i >= 0; i--)
    begin
      if (kok_r[i] && kid_r[i] == key.id)
        hit = 1'b1;
      if (!kok_r[i])
      begin
        free = 1'b1;
        slot = i[$clog2(KEYS)-1:0];
      end
    end
  end

  // ------------------------------------------------------------
  // Tick prescaler and input timers
  // ------------------------------------------------------------
  // One tick paces every pattern and window
  always_comb
  begin
    tick_nxt = (div_r == DIV_W'(TICK_CYC - 1));
    div_nxt  = tick_nxt ? '0 : div_r + 1'b1;
    off_nxt  = off_r;
    pw_nxt   = pw_r;
    if (ign_rise)
      pw_nxt = '0;
    else if (tick_r && s2_r.ign && pw_r != '1)
      pw_nxt = pw_r + 1'b1;
    if (ign_fall)
      off_nxt = '0;
    else if (tick_r && !s2_r.ign && off_r != '1)
      off_nxt = off_r + 1'b1;
  end

  // ------------------------------------------------------------
  // Mode sequencer
  // ------------------------------------------------------------
  // Next mode, flags, key table and code
  always_comb
  begin
    st_nxt     = st_r;
    svc_nxt    = svc_r;
    learnt_nxt = learnt_r;
    resync_nxt = resync_r;
    arm_nxt    = arm_r;
    door_nxt   = door_r;
    kok_nxt    = kok_r;
    kid_nxt    = kid_r;
    do_code    = 1'b0;
    do_link    = 1'b0;
    rst_t      = 1'b0;
    bp_load    = '0;
    dbl_nxt    = dbl_r;
    led_m      = LED_OFF;
    // Where ignition on leads from rest
    go_res = resync_r && off_r >= OFF15_T;
    on_st  = svc_r ? ST_SVC_ON : ST_READ;
    if (!go_res && learnt_r && !s2_r.ctl_match)
      on_st = ST_UNSYNC;
    unique case (st_r)
      ST_IDLE, ST_SLEEP:
      begin
        led_m = (st_r == ST_SLEEP) ? LED_SLEEP : LED_OFF;
        if (ign_rise)
        begin
          st_nxt  = on_st;
          arm_nxt = 1'b0;
          door_nxt = 1'b0;
          if (go_res)
          begin
            do_code    = 1'b1;
            resync_nxt = 1'b0;
          end
        end
        else if (st_r == ST_IDLE)
        begin
          if (s2_r.door)
            door_nxt = 1'b1;
          if (door_r && door_close)
          begin
            arm_nxt = 1'b1;
            rst_t   = 1'b1;
          end
          if (arm_r && t_r >= ARM_T)
            st_nxt = ST_SLEEP;
        end
      end
      ST_READ:
      begin
        led_m = LED_2HZ;
        if (ign_fall && mk)
        begin
          st_nxt  = ST_MK1;
          bp_load = SHORT_B;
        end
        else if (ign_fall)
          st_nxt = ST_IDLE;
        else if (ord_ev && (hit || !learnt_r))
        begin
          st_nxt  = ST_RUN;
          do_link = 1'b1;
          bp_load = DBL_B;
          dbl_nxt = 1'b1;
        end
      end
      ST_RUN:
      begin
        // Steady forever: module not learnt; 20 s: new controller
        if (!learnt_r || (s2_r.ctl_new && t_r < NEWCTL_T))
          led_m = LED_ON;
        if (ign_fall)
          st_nxt = ST_IDLE;
      end
      ST_UNSYNC:
      begin
        led_m = svc_r ? LED_HALF : LED_1HZ;
        if (ign_fall)
        begin
          st_nxt     = ST_IDLE;
          resync_nxt = 1'b1;
        end
      end
      ST_MK1, ST_MK2:
      begin
        led_m = LED_ON;
        if (ign_rise)
          st_nxt = ST_ABORT;
        else if (t_r >= SETTLE_T)
        begin
          if (mk)
            st_nxt = ST_ABORT;
          else
            st_nxt = (st_r == ST_MK1) ? ST_WIN1 : ST_ENROLL;
        end
      end
      ST_WIN1:
      begin
        led_m = LED_BURST;
        if (mk)
        begin
          st_nxt  = ST_CONF;
          bp_load = LONG_B;
        end
        else if (ign_rise || t_r >= WIN_T)
          st_nxt = ST_ABORT;
      end
      ST_CONF, ST_EXIT:
      begin
        led_m = LED_ON;
        if (ign_fall && pw_r >= PMIN_T && pw_r <= PMAX_T)
        begin
          if (st_r == ST_CONF)
            st_nxt = ST_DONE;
          else
          begin
            st_nxt     = ST_IDLE;
            svc_nxt    = 1'b0;
            learnt_nxt = 1'b1;
            do_code    = 1'b1;
            bp_load    = SHORT_B;
          end
        end
        else if (ign_fall || t_r >= WIN_T)
          st_nxt = ST_ABORT;
      end
      ST_DONE:
      begin
        led_m = LED_ON;
        if (t_r >= LEDOFF_T)
        begin
          st_nxt  = ST_IDLE;
          bp_load = SHORT_B;
          svc_nxt = 1'b1;
          kok_nxt = '0;
          do_code = 1'b1;
        end
      end
      ST_SVC_ON:
      begin
        led_m = LED_ON;
        if (ign_fall && mk)
        begin
          st_nxt  = ST_MK2;
          bp_load = SHORT_B;
        end
        else if (ign_fall)
          st_nxt = ST_IDLE;
      end
      ST_ENROLL:
      begin
        led_m = (bp_r != '0) ? LED_OFF : LED_10HZ;
        if (mk)
        begin
          st_nxt  = ST_EXIT;
          bp_load = LONG_B;
        end
        else if (ord_ev && (hit || free))
        begin
          if (!hit)
          begin
            kok_nxt[slot] = 1'b1;
            kid_nxt[slot] = key.id;
          end
          bp_load = LONG_B;
          rst_t   = 1'b1;
        end
        else if (ign_rise || t_r >= WIN_T)
          st_nxt = ST_ABORT;
      end
      ST_ABORT:
      begin
        led_m = LED_2HZ;
        if (t_r >= ABORT_T)
          st_nxt = s2_r.ign ? on_st : ST_IDLE;
      end
    endcase
    // Window time restarts on every mode change
    if (st_nxt != st_r || rst_t)
      t_nxt = '0;
    else if (tick_r && t_r != '1)
      t_nxt = t_r + 1'b1;
    else
      t_nxt = t_r;
    // Fresh code goes to nvm, controller and master key
    cw       = do_code;
    code_nxt = do_code ? lfsr_r : code_r;
    // A new request wins over a finishing acknowledge
    link_nxt = (link_r && !s2_r.ack) || do_link || do_code;
    // Beeper countdown, double beep has a gap
    if (bp_load != '0)
      bp_nxt = bp_load;
    else if (tick_r && bp_r != '0)
      bp_nxt = bp_r - 1'b1;
    else
      bp_nxt = bp_r;
    if (bp_load != '0 && bp_load != DBL_B)
      dbl_nxt = 1'b0;
    beep_on = (bp_r != '0) && (!dbl_r || bp_r > (DBL_B - SHORT_B) || bp_r <= SHORT_B);
    // Output values
    out_nxt.led      = led_pat(led_m, t_r);
    out_nxt.beep     = beep_on;
    out_nxt.fuel     = (st_r == ST_RUN) || (st_r == ST_SVC_ON);
    out_nxt.relay    = s2_r.tool && !link_r;
    out_nxt.link_req = link_r;
    out_nxt.code_wr  = cw;
    out_nxt.learnt   = learnt_r;
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  // Synchroniser, divider and timers
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      s1_r     <= '0;
      s2_r     <= '0;
      div_r    <= '0;
      tick_r   <= 1'b0;
      off_r    <= '0;
      pw_r     <= '0;
      ign_q_r  <= 1'b0;
      door_q_r <= 1'b0;
      kp_q_r   <= 1'b0;
      lfsr_r   <= LFSR_SEED;
    end
    else
    begin
      s1_r     <= pins;
      s2_r     <= s1_r;
      div_r    <= div_nxt;
      tick_r   <= tick_nxt;
      off_r    <= off_nxt;
      pw_r     <= pw_nxt;
      ign_q_r  <= s2_r.ign;
      door_q_r <= s2_r.door;
      kp_q_r   <= key.present;
      lfsr_r   <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
    end
  end

  // Mode, flags, key table, code and outputs
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      st_r     <= ST_IDLE;
      t_r      <= '0;
      svc_r    <= 1'b0;
      learnt_r <= 1'b0;
      resync_r <= 1'b0;
      arm_r    <= 1'b0;
      door_r   <= 1'b0;
      link_r   <= 1'b0;
      bp_r     <= '0;
      dbl_r    <= 1'b0;
      code_r   <= CODE_RST;
      kok_r    <= '0;
      kid_r    <= '{default: '0};
      out_r    <= '0;
    end
    else
    begin
      st_r     <= st_nxt;
      t_r      <= t_nxt;
      svc_r    <= svc_nxt;
      learnt_r <= learnt_nxt;
      resync_r <= resync_nxt;
      arm_r    <= arm_nxt;
      door_r   <= door_nxt;
      link_r   <= link_nxt;
      bp_r     <= bp_nxt;
      dbl_r    <= dbl_nxt;
      code_r   <= code_nxt;
      kok_r    <= kok_nxt;
      kid_r    <= kid_nxt;
      out_r    <= out_nxt;
    end
  end

  assign drv      = out_r;
  assign sys_code = code_r;
endmodule : tds_top
`default_nettype wire

// ---- verification/tds_sva.sv ----
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Port checker for the mode sequencer
// ----------------------------------------
module tds_chk #(
  parameter int TICK_CYC = tds_pkg::TICK_CYC     // Cycles per tick
) (
  input wire logic                       ref_clk,  // Clock
  input wire logic                       reset,    // Async reset
  input wire tds_pkg::tds_pins_t         pins,     // Pin inputs
  input wire tds_pkg::tds_key_t          key,      // Key reader
  input wire tds_pkg::tds_out_t          drv,      // Outputs
  input wire logic [tds_pkg::CODE_W-1:0] sys_code  // Current code
);
  import tds_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // Tool pin low long enough to pass the synchroniser
  sequence s_no_tool;
    (!pins.tool) [*4];
  endsequence
  // Tool present and no own exchange pending
  sequence s_tool_free;
    (pins.tool && !drv.link_req) [*5];
  endsequence
  // Ignition off long enough to leave the running states
  sequence s_ign_off;
    (!pins.ign) [*8];
  endsequence
  property p_relay_open;
    s_no_tool |-> !drv.relay;
  endproperty
  a_relay_open: assert property (p_relay_open)
    else $error("relay closed with no tool");
  property p_relay_close;
    s_tool_free |-> drv.relay;
  endproperty
  a_relay_close: assert property (p_relay_close)
    else $error("relay open with tool and idle line");
  property p_relay_yield;
    $rose(drv.link_req) |=> !drv.relay;
  endproperty
  a_relay_yield: assert property (p_relay_yield)
    else $error("relay kept closed during own exchange");
  // The exchange request follows the code store strobe by one cycle
  property p_code_link;
    drv.code_wr |=> drv.link_req;
  endproperty
  a_code_link: assert property (p_code_link)
    else $error("code store without line exchange");
  property p_fuel_ign;
    s_ign_off |-> !drv.fuel;
  endproperty
  a_fuel_ign: assert property (p_fuel_ign)
    else $error("fuel granted with ignition off");
  property p_learnt_keep;
    drv.learnt |=> drv.learnt;
  endproperty
  a_learnt_keep: assert property (p_learnt_keep)
    else $error("learnt state lost");
  property p_code_pulse;
    drv.code_wr |=> !drv.code_wr;
  endproperty
  a_code_pulse: assert property (p_code_pulse)
    else $error("code store longer than one cycle");
  property p_code_new;
    drv.code_wr |-> sys_code != $past(sys_code);
  endproperty
  a_code_new: assert property (p_code_new)
    else $error("code store without fresh code");
  property p_code_hold;
    !drv.code_wr |-> sys_code == $past(sys_code);
  endproperty
  a_code_hold: assert property (p_code_hold)
    else $error("code changed without store");
endmodule : tds_chk
bind tds_top tds_chk #(.TICK_CYC(TICK_CYC)) tds_chk_i (.ref_clk(ref_clk), .reset(reset), .pins(pins),
  .key(key), .drv(drv), .sys_code(sys_code));
`default_nettype wire

// ---- verification/tds_ctl_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Engine controller on the diagnostic line
// ----------------------------------------
module tds_ctl_model #(
  parameter int DLY = 6                             // Answer delay in cycles
) (
  input  wire logic                       ref_clk,   // Clock
  input  wire logic                       reset,     // Reset
  input  wire logic                       link_req,  // Module exchange pending
  input  wire logic                       code_wr,   // Code store strobe
  input  wire logic                       learnt,    // Module bound
  input  wire logic [tds_pkg::CODE_W-1:0] sys_code,  // Code from module
  output var  logic                       ack,       // Exchange done
  output var  logic                       ctl_new,   // Controller still new
  output var  logic                       ctl_match  // Stored code agrees
);
  import tds_pkg::*;
  logic [CODE_W-1:0] code_r; // Code in controller memory
  int                wait_r; // Cycles spent on this exchange
  // Code comparison against the module's code
  assign ctl_match = (code_r == sys_code);
  // Answer each exchange late, store codes, bind once
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      code_r <= CODE_RST;
      wait_r <= 0;
      ack <= 1'b0;
      ctl_new <= 1'b1;
    end
    else
    begin
      wait_r <= link_req ? wait_r + 1 : 0;
      ack <= link_req && (wait_r >= DLY);
      if (code_wr)
        code_r <= sys_code;
      if (learnt)
        ctl_new <= 1'b0;
    end
  end
endmodule : tds_ctl_model
`default_nettype wire

// ---- verification/tds_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb;
  import tds_pkg::*;
  localparam int TK = 4;             // Cycles per tick
  logic              ref_clk = 1'b0; // Clock
  logic              reset   = 1'b1; // Reset
  logic              ign     = 1'b0; // Ignition
  logic              door    = 1'b0; // Driver door
  logic              tool    = 1'b0; // Scan tool
  tds_key_t          key     = '0;   // Key reader
  logic              ack, cnew, cmat; // Controller answers
  tds_pins_t         pins;           // Assembled pins
  tds_out_t          drv;            // Outputs
  logic [CODE_W-1:0] sys_code;       // Code
  int bad_count = 0;                 // Mismatches
  int comparisons = 0;               // Comparisons
  assign pins = {ign, door, tool, ack, cnew, cmat};
  always #4 ref_clk = ~ref_clk;
  tds_top #(.TICK_CYC(TK)) tds_top_i (.ref_clk(ref_clk), .reset(reset), .pins(pins), .key(key),
    .drv(drv), .sys_code(sys_code));
  tds_ctl_model #(.DLY(6)) tds_ctl_model_i (.ref_clk(ref_clk), .reset(reset), .link_req(drv.link_req),
    .code_wr(drv.code_wr), .learnt(drv.learnt), .sys_code(sys_code), .ack(ack), .ctl_new(cnew),
    .ctl_match(cmat));
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    comparisons++;
    if (s !== e)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // Count indicator on-cycles over a window
  task automatic led_chk(input string n, input int w, input int e);
    int c;
    c = 0;
    repeat (w)
    begin
      @(posedge ref_clk);
      if (drv.led === 1'b1)
        c++;
    end
    chk(n, 16'(e), 16'(c));
  endtask : led_chk
  task automatic report_and_stop();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  // Bounded wait for the code store pulse
  task automatic wt_code(input int n);
    int i;
    i = 0;
    while (drv.code_wr !== 1'b1 && i < n)
    begin
      cyc(1);
      i++;
    end
    chk("code_wr", 16'h1, 16'(drv.code_wr));
    // Only a strobe that never came ends the run here
    if (drv.code_wr !== 1'b1)
      report_and_stop();
  endtask : wt_code
  // Master at ignition off, then settle into the window
  task automatic mk_off(input string n);
    key <= '{present: 1'b1, master: 1'b1, id: 8'h01};
    cyc(4);
    ign <= 1'b0;
    cyc(10);
    chk({n, " led"}, 16'h1, 16'(drv.led));
    chk({n, " beep"}, 16'h1, 16'(drv.beep));
    key <= '0;
    cyc((int'(SETTLE_T) + 4) * TK);
  endtask : mk_off
  // Master again, then a mid-length ignition pulse
  task automatic confirm(input string n);
    logic [CODE_W-1:0] old;
    key <= '{present: 1'b1, master: 1'b1, id: 8'h01};
    cyc(8);
    chk({n, " beep"}, 16'h1, 16'(drv.beep));
    key <= '0;
    ign <= 1'b1;
    old = sys_code;
    cyc(60 * TK);
    ign <= 1'b0;
    wt_code(2000);
    chk("fresh code", 16'h1, 16'(sys_code !== old));
  endtask : confirm
  task automatic t_base();
    tool <= 1'b1;
    cyc(6);
    chk("relay", 16'h1, 16'(drv.relay));
    tool <= 1'b0;
    cyc(6);
    chk("relay", 16'h0, 16'(drv.relay));
    tool <= 1'b1;
    door <= 1'b1;
    cyc(8);
    door <= 1'b0;
    cyc(int'(ARM_T) * TK + 40);
    led_chk("sleep led", int'(SLEEP_T) * TK, int'(FLASH_T) * TK);
    $display("t_base done");
  endtask : t_base
  task automatic t_read();
    ign <= 1'b1;
    cyc(10);
    led_chk("read led", int'(F2_T) * TK, int'(F2_T >> 1) * TK);
    key <= '{present: 1'b1, master: 1'b0, id: 8'h22};
    cyc(20);
    chk("fuel", 16'h1, 16'(drv.fuel));
    key <= '0;
    ign <= 1'b0;
    cyc(12);
    chk("fuel", 16'h0, 16'(drv.fuel));
    $display("t_read done");
  endtask : t_read
  task automatic t_svc();
    ign <= 1'b1;
    cyc(10);
    mk_off("enter");
    led_chk("burst", int'(BURST_T) * TK, int'(SEC_T / F10_T) * int'(F10_T >> 1) * TK);
    confirm("enter");
    cyc(4);
    ign <= 1'b1;
    cyc(20);
    led_chk("svc led", int'(SEC_T) * TK, int'(SEC_T) * TK);
    chk("fuel", 16'h1, 16'(drv.fuel));
    mk_off("exit");
    led_chk("enroll", int'(F10_T) * TK, int'(F10_T >> 1) * TK);
    key <= '{present: 1'b1, master: 1'b0, id: 8'h22};
    cyc(8);
    chk("enroll beep", 16'h1, 16'(drv.beep));
    chk("enroll led", 16'h0, 16'(drv.led));
    key <= '0;
    cyc(50 * TK);
    confirm("exit");
    cyc(2);
    chk("learnt", 16'h1, 16'(drv.learnt));
    $display("t_svc done");
  endtask : t_svc
  task automatic t_learnt();
    ign <= 1'b1;
    cyc(10);
    key <= '{present: 1'b1, master: 1'b0, id: 8'h33};
    cyc(20);
    chk("fuel", 16'h0, 16'(drv.fuel));
    key <= '0;
    cyc(4);
    key <= '{present: 1'b1, master: 1'b0, id: 8'h22};
    cyc(20);
    chk("fuel", 16'h1, 16'(drv.fuel));
    key <= '0;
    ign <= 1'b0;
    cyc(12);
    $display("t_learnt done");
  endtask : t_learnt
  // Master left at the reader past the settle time aborts the entry
  task automatic t_abort();
    ign <= 1'b1;
    cyc(10);
    key <= '{present: 1'b1, master: 1'b1, id: 8'h01};
    cyc(4);
    ign <= 1'b0;
    cyc((int'(SETTLE_T) + 4) * TK);
    led_chk("abort led", int'(F2_T) * TK, int'(F2_T >> 1) * TK);
    key <= '0;
    cyc((int'(ABORT_T) + 4) * TK);
    chk("abort end led", 16'h0, 16'(drv.led));
    chk("learnt", 16'h1, 16'(drv.learnt));
    $display("t_abort done");
  endtask : t_abort
  initial
  begin
    cyc(12);
    reset <= 1'b0;
    cyc(2);
    t_base();
    t_read();
    t_svc();
    t_learnt();
    t_abort();
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
